// ===== logic/mao_bank_map.sv
// bank decode: forms the full data address and classifies it
`timescale 1ns/10ps
module mao_bank_map (
   // request and bank state
   input wire mao_pkg::mao_data_req_t req,
   input wire logic [1:0] bank_sel,
   input wire logic [7:0] pointer,
   input wire logic bank_sel_ind,
   // resolved access
   output mao_pkg::mao_data_acc_t acc
);
   logic [8:0] addr;

   always_comb begin
      if (req.file_addr == mao_pkg::ADDR_INDIRECT) begin
         addr = {bank_sel_ind, pointer}; // RULE10
      end else begin
         addr = {bank_sel, req.file_addr}; // RULE11 RULE6
      end
      acc.valid = req.valid;
      acc.write = req.write;
      acc.addr = addr;
      acc.is_sfr = (addr[6:0] <= mao_pkg::SFR_TOP); // RULE8 RULE9
      acc.wdata = req.wdata;
   end
endmodule // mao_bank_map

// ===== logic/mao_core.sv
// program counter and banked data memory of the core
// Notes on behaviour
// [RULE1] program counter is 13 bits, reaching 8K words of 14 bits
// [RULE2] with only 4K words built, fetches above wrap into the built memory
// [RULE3] reset loads the program counter with 0000h
// [RULE4] taking an interrupt loads the program counter with 0004h
// [RULE5] fetch and data access use separate buses, both usable each cycle
// [RULE6] status bits 6 and 5 select banks 0 to 3
// [RULE7] each bank spans offsets 00h to 7Fh, 128 bytes
// [RULE8] low offsets of each bank are special registers, above is static ram
// [RULE9] every bank has special registers; core ones mirror across banks
// [RULE10] data reachable directly in the bank or indirectly via the pointer
// [RULE11] direct address is bank bits above the 7-bit file field
`timescale 1ns/10ps
module mao_core #(
   parameter int IMPL_WORDS = mao_pkg::PROG_WORDS
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // program side
   input wire mao_pkg::mao_pc_req_t pc_req,
   output logic [12:0] pc,
   output logic [12:0] fetch_addr,
   input wire logic [13:0] fetch_word,
   output logic [13:0] instr,
   // data side
   input wire mao_pkg::mao_data_req_t dreq,
   output logic [7:0] rdata,
   output logic rdata_is_sfr,
   output logic [8:0] data_addr,
   // peripheral special register port
   output logic sfr_wr,
   output logic [8:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // visible bank state
   output logic [1:0] bank_sel
);
   localparam int IMPL_W = $clog2(IMPL_WORDS);
   localparam int RAM_N = 512;

   logic [12:0] pc_q, pc_d;
   logic [13:0] instr_q, instr_d;
   logic [7:0] status_q, status_d;
   logic [7:0] pointer_q, pointer_d;
   logic [7:0] pc_latch_q, pc_latch_d;
   logic [7:0] rdata_q, rdata_d;
   logic sfr_q, sfr_d;
   logic [8:0] daddr_q, daddr_d;
   logic [7:0] ram [RAM_N];
   mao_pkg::mao_data_acc_t acc;
   logic [12:0] wrap_mask;

   ////////////////////////////////////////////////////////////////////////////
   // program counter

   assign wrap_mask = 13'((1 << IMPL_W) - 1); // RULE2

   always_comb begin
      pc_d = pc_q;
      if (pc_req.irq_take) begin
         pc_d = mao_pkg::IRQ_VEC; // RULE4
      end else if (pc_req.jump) begin
         pc_d = pc_req.jump_addr;
      end else if (!pc_req.stall) begin
         pc_d = 13'(pc_q + 13'h0001); // RULE1
      end
      instr_d = fetch_word;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pc_q <= mao_pkg::RESET_VEC; // RULE3
         instr_q <= 14'h0000;
      end else begin
         pc_q <= pc_d;
         instr_q <= instr_d;
      end
   end

   assign pc = pc_q;
   assign fetch_addr = pc_q & wrap_mask; // RULE2 RULE5
   assign instr = instr_q;

   ////////////////////////////////////////////////////////////////////////////
   // data side

   mao_bank_map u_map (
      .req(dreq),
      .bank_sel(status_q[mao_pkg::STATUS_BSEL_HI:mao_pkg::STATUS_BSEL_LO]),
      .pointer(pointer_q),
      .bank_sel_ind(status_q[7]),
      .acc(acc)
   );

   assign bank_sel = status_q[mao_pkg::STATUS_BSEL_HI:mao_pkg::STATUS_BSEL_LO]; // RULE6

   always_comb begin
      status_d = status_q;
      pointer_d = pointer_q;
      pc_latch_d = pc_latch_q;
      rdata_d = rdata_q;
      sfr_d = sfr_q;
      daddr_d = daddr_q;
      if (acc.valid) begin // RULE5
         sfr_d = acc.is_sfr;
         daddr_d = acc.addr;
         if (!acc.is_sfr) begin
            rdata_d = ram[acc.addr]; // RULE8
         end else begin
            unique case (acc.addr[6:0]) // RULE9
               mao_pkg::ADDR_STATUS: rdata_d = status_q;
               mao_pkg::ADDR_POINTER: rdata_d = pointer_q;
               mao_pkg::ADDR_PC_LATCH: rdata_d = pc_latch_q;
               mao_pkg::ADDR_INDIRECT: rdata_d = 8'h00;
               default: rdata_d = sfr_rdata;
            endcase
         end
         if (acc.write && acc.is_sfr) begin
            unique case (acc.addr[6:0])
               mao_pkg::ADDR_STATUS: status_d = acc.wdata; // RULE6
               mao_pkg::ADDR_POINTER: pointer_d = acc.wdata; // RULE10
               mao_pkg::ADDR_PC_LATCH: pc_latch_d = acc.wdata;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         status_q <= mao_pkg::STATUS_RST;
         pointer_q <= mao_pkg::POINTER_RST;
         pc_latch_q <= 8'h00;
         rdata_q <= 8'h00;
         sfr_q <= 1'b0;
         daddr_q <= 9'h000;
      end else begin
         status_q <= status_d;
         pointer_q <= pointer_d;
         pc_latch_q <= pc_latch_d;
         rdata_q <= rdata_d;
         sfr_q <= sfr_d;
         daddr_q <= daddr_d;
      end
   end

   // static ram above the special registers, 96 locations per bank
   always_ff @(posedge clock) begin
      if (acc.valid && acc.write && !acc.is_sfr) begin
         ram[acc.addr] <= acc.wdata; // RULE7 RULE8
      end
   end

   assign sfr_wr = acc.valid && acc.write && acc.is_sfr;
   assign sfr_addr = acc.addr;
   assign sfr_wdata = acc.wdata;
   assign rdata = rdata_q;
   assign rdata_is_sfr = sfr_q;
   assign data_addr = daddr_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   pc_reset_vec_a: assert property (@(posedge clock) // RULE3
      !rst_n |=> pc == mao_pkg::RESET_VEC) else $error("pc not at reset vector");
   pc_irq_vec_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
      pc_req.irq_take |=> pc == mao_pkg::IRQ_VEC) else $error("pc not at irq vector");
   pc_step_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
      !pc_req.irq_take && !pc_req.jump && !pc_req.stall
      |=> pc == 13'($past(pc) + 13'h0001)) else $error("pc did not step");
   fetch_wrap_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
      fetch_addr == 13'(int'(pc) % IMPL_WORDS)) else $error("fetch beyond built memory");
   direct_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE11
      dreq.valid && dreq.file_addr != mao_pkg::ADDR_INDIRECT
      |=> data_addr == {$past(bank_sel), $past(dreq.file_addr)})
      else $error("direct address misformed");
   indirect_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
      dreq.valid && dreq.file_addr == mao_pkg::ADDR_INDIRECT
      |=> data_addr == {$past(status_q[7]), $past(pointer_q)})
      else $error("indirect address wrong");
   bank_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
      dreq.valid && dreq.write && dreq.file_addr == mao_pkg::ADDR_STATUS
      |=> bank_sel == $past(dreq.wdata[mao_pkg::STATUS_BSEL_HI:mao_pkg::STATUS_BSEL_LO]))
      else $error("bank bits not taken");
   sfr_class_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
      dreq.valid && dreq.file_addr != mao_pkg::ADDR_INDIRECT
      |=> rdata_is_sfr == ($past(dreq.file_addr) <= mao_pkg::SFR_TOP))
      else $error("sfr class wrong");
   concurrent_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
      dreq.valid && !pc_req.stall && !pc_req.jump && !pc_req.irq_take
      |=> pc != $past(pc)) else $error("fetch blocked by data access");
endmodule // mao_core

// ===== shared/mao_pkg.sv
// package of constants and carrier types for the memory address organiser
package mao_pkg;
   localparam int PC_W = 13;
   localparam int WORD_W = 14;
   localparam int PROG_WORDS = 8192;
   localparam logic [12:0] RESET_VEC = 13'h0000;
   localparam logic [12:0] IRQ_VEC = 13'h0004;
   localparam int STATUS_BSEL_HI = 6;
   localparam int STATUS_BSEL_LO = 5;
   localparam int BANK_OFS_W = 7;
   localparam logic [6:0] BANK_TOP = 7'h7f;
   localparam int DADDR_W = 9;
   localparam logic [6:0] SFR_TOP = 7'h1f;
   localparam logic [6:0] ADDR_INDIRECT = 7'h00;
   localparam logic [6:0] ADDR_STATUS = 7'h03;
   localparam logic [6:0] ADDR_POINTER = 7'h04;
   localparam logic [6:0] ADDR_PC_LATCH = 7'h0a;
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] POINTER_RST = 8'h00;

   // pc sequencing request from the core
   typedef struct packed {
      logic irq_take;
      logic jump;
      logic [12:0] jump_addr;
      logic stall;
   } mao_pc_req_t;

   // data access request from the core
   typedef struct packed {
      logic valid;
      logic write;
      logic [6:0] file_addr;
      logic [7:0] wdata;
   } mao_data_req_t;

   // resolved data target
   typedef struct packed {
      logic valid;
      logic write;
      logic is_sfr;
      logic [8:0] addr;
      logic [7:0] wdata;
   } mao_data_acc_t;
endpackage

// ===== sim/mao_core_test.sv
// self-checking testbench of the memory address organiser core
`timescale 1ns/10ps
module mao_core_test;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   mao_pkg::mao_pc_req_t pc_req = '0;
   mao_pkg::mao_data_req_t dreq = '0;
   logic [12:0] pc, fetch_addr;
   logic [13:0] fetch_word, instr;
   logic [7:0] rdata;
   logic rdata_is_sfr;
   logic [8:0] data_addr;
   logic [1:0] bank_sel;
   logic sfr_wr;
   logic [8:0] sfr_addr;
   logic [7:0] sfr_wdata;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   // program memory model answers the fetch address in the same cycle
   assign fetch_word = {1'b1, fetch_addr};
   mao_core #(.IMPL_WORDS(4096)) dut (.clock(clock), .rst_n(rst_n), .pc_req(pc_req), .pc(pc),
      .fetch_addr(fetch_addr), .fetch_word(fetch_word), .instr(instr), .dreq(dreq),
      .rdata(rdata), .rdata_is_sfr(rdata_is_sfr), .data_addr(data_addr), .sfr_wr(sfr_wr),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(8'h5a), .bank_sel(bank_sel));
   always #2 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one data access taken at the next rising edge
   task acc(input logic w, input logic [6:0] a, input logic [7:0] d);
      dreq = {1'b1, w, a, d};
      @(negedge clock);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task t_prog;
      pc_req = {1'b0, 1'b1, 13'h1ffd, 1'b0};
      @(negedge clock);
      chk("pc", 16'(pc), 16'h1ffd);
      chk("fetch_addr", 16'(fetch_addr), 16'h0ffd);
      pc_req = '0;
      @(negedge clock);
      chk("pc", 16'(pc), 16'h1ffe);
      chk("fetch_addr", 16'(fetch_addr), 16'h0ffe);
      pc_req = {1'b1, 1'b1, 13'h0100, 1'b0};
      @(negedge clock);
      chk("pc irq", 16'(pc), 16'h0004);
      pc_req = {1'b0, 1'b0, 13'h0000, 1'b1};
      @(negedge clock);
      $display("test prog done");
   endtask
   task t_bank;
      for (int b = 0; b < 4; b++) begin
         acc(1'b1, 7'h03, {1'b0, 2'(b), 5'h18});
         chk("bank_sel", 16'(bank_sel), 16'(b));
         acc(1'b1, 7'h7f, 8'ha0 + 8'(b));
         chk("sfr_wr ram", 16'(sfr_wr), 16'h0000);
         acc(1'b1, 7'h1e, 8'h60 + 8'(b));
         chk("sfr_wr", 16'(sfr_wr), 16'h0001);
         chk("sfr_addr", 16'(sfr_addr), 16'({2'(b), 7'h1e}));
         chk("sfr_wdata", 16'(sfr_wdata), 16'(8'h60 + 8'(b)));
         acc(1'b0, 7'h03, 8'h00);
         chk("status mirror", 16'(rdata[6:5]), 16'(b));
         chk("sfr flag", 16'(rdata_is_sfr), 16'h0001);
         acc(1'b0, 7'h1f, 8'h00);
         chk("sfr port", 16'(rdata), 16'h005a);
         chk("sfr addr", 16'(data_addr), 16'({2'(b), 7'h1f}));
      end
      for (int b = 0; b < 4; b++) begin
         acc(1'b1, 7'h03, {1'b0, 2'(b), 5'h18});
         acc(1'b0, 7'h7f, 8'h00);
         chk("ram data", 16'(rdata), 16'(8'ha0 + 8'(b)));
         chk("ram flag", 16'(rdata_is_sfr), 16'h0000);
         chk("ram addr", 16'(data_addr), 16'({2'(b), 7'h7f}));
      end
      chk("pc held", 16'(pc), 16'h0004);
      chk("instr", 16'(instr), 16'h3ffc & 16'h2004);
      dreq = '0;
      @(negedge clock);
      $display("test bank done");
   endtask
   task t_indirect;
      acc(1'b1, 7'h03, 8'h18);
      acc(1'b1, 7'h20, 8'h3c);
      acc(1'b1, 7'h04, 8'h20);
      acc(1'b0, 7'h00, 8'h00);
      chk("ind addr", 16'(data_addr), 16'h0020);
      chk("ind data", 16'(rdata), 16'h003c);
      acc(1'b1, 7'h00, 8'hc3);
      acc(1'b0, 7'h20, 8'h00);
      chk("direct data", 16'(rdata), 16'h00c3);
      acc(1'b1, 7'h03, 8'h98);
      acc(1'b0, 7'h00, 8'h00);
      chk("ind bank addr", 16'(data_addr), 16'h0120);
      chk("pc concurrent", 16'(pc), 16'h0008);
      dreq = '0;
      @(negedge clock);
      $display("test indirect done");
   endtask
   // reset held for n cycles, from any state
   task t_reset(input int n);
      rst_n = 1'b0;
      pc_req = '0;
      dreq = '0;
      repeat (n) @(negedge clock);
      rst_n = 1'b1;
      chk("pc reset", 16'(pc), 16'h0000);
      chk("bank reset", 16'(bank_sel), 16'h0000);
      $display("test reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      t_reset(10);
      t_prog();
      t_bank();
      t_reset(2);
      t_indirect();
      results();
   end
endmodule // mao_core_test
